//--- common/serial_dac_map.svh
// constants for the dual converter serial load link
// assumes inclusion by the package and both ends by bare name
`ifndef SERIAL_DAC_MAP_SVH
`define SERIAL_DAC_MAP_SVH
`define WORD_BITS      14
`define CODE_BITS      12
`define ADDR_BITS      2
`define ADDR_HI_POS    13
`define ADDR_LO_POS    12
`define CODE_MSB_POS   11
`define CODE_RESET     12'h000
`define WORD_RESET     14'h0000
`define STEP_UV        1000
`define FULL_SCALE_MV  4095
`endif

//--- common/serial_dac_pkg.sv
// types shared by both ends of the serial converter link
// assumes the map header sits beside it
`include "serial_dac_map.svh"
package serial_dac_pkg;
    typedef logic [`CODE_BITS-1:0] code_t;
    typedef logic [`WORD_BITS-1:0] word_t;
    typedef enum logic [1:0] {
        load_both_t,
        load_both2_t,
        load_a_t,
        load_b_t
    } addr_sel_t;
endpackage : serial_dac_pkg

//--- common/serial_dac_if.sv
// wires between the host end and the converter end
// assumes one shared clock; all pins are one-way
interface serial_dac_if;
    logic serial_in_line;
    logic serial_clk;
    logic chip_sel_n;
    logic dac_latch_strobe_n;
    modport host
    (
        output serial_in_line,
        output serial_clk,
        output chip_sel_n,
        output dac_latch_strobe_n
    );
    modport device
    (
        input serial_in_line,
        input serial_clk,
        input chip_sel_n,
        input dac_latch_strobe_n
    );
endinterface : serial_dac_if

//--- verilog/dac_serial_device.sv
// converter end: shift register and two double-buffered code registers
// assumes link pins synchronous to clock; serial clock sampled for edges
`include "serial_dac_map.svh"

module dac_serial_device
    import serial_dac_pkg::*;
(
    input  wire logic    clock,
    input  wire logic    rst_b,
    input  wire logic    clk_en,
    serial_dac_if.device link,
    output code_t        code_a,
    output code_t        code_b,
    output logic [15:0]  millivolt_a,
    output logic [15:0]  millivolt_b
);
    // ****************************************
    // serial capture
    // ****************************************
    word_t shift_reg;
    word_t shift_next;
    logic  sclk_reg;
    logic  cap_bit;
    assign cap_bit = link.serial_clk & ~sclk_reg & ~link.chip_sel_n;
    assign shift_next = cap_bit ? {shift_reg[`WORD_BITS-2:0], link.serial_in_line} : shift_reg;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shift_reg <= `WORD_RESET;
            sclk_reg  <= 1'b0;
        end
        else if (clk_en)
        begin
            shift_reg <= shift_next;
            sclk_reg  <= link.serial_clk;
        end
    end

    // ****************************************
    // address decode and transparent load
    // ****************************************
    // the latch is modelled as follow-per-cycle, so code outputs update on the same clock as the shifter; millivolts follow one clock later
    logic  addr_hi;
    logic  addr_lo;
    logic  hit_a;
    logic  hit_b;
    logic  open_w;
    code_t word_code;
    assign addr_hi   = shift_next[`ADDR_HI_POS];
    assign addr_lo   = shift_next[`ADDR_LO_POS];
    assign hit_a     = ~addr_hi | ~addr_lo;
    assign hit_b     = ~addr_hi | addr_lo;
    assign open_w    = ~link.dac_latch_strobe_n;
    assign word_code = shift_next[`CODE_MSB_POS:0];

    code_t a_reg;
    code_t b_reg;
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            a_reg <= `CODE_RESET;
            b_reg <= `CODE_RESET;
        end
        else if (clk_en && open_w)
        begin
            if (hit_a)
                a_reg <= word_code;
            if (hit_b)
                b_reg <= word_code;
        end
        // strobe high: held codes untouched while shifting
    end

    // ****************************************
    // ideal output in millivolts
    // ****************************************
    logic [15:0] mv_a_reg;
    logic [15:0] mv_b_reg;
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mv_a_reg <= 16'h0000;
            mv_b_reg <= 16'h0000;
        end
        else if (clk_en)
        begin
            mv_a_reg <= {4'h0, a_reg};
            mv_b_reg <= {4'h0, b_reg};
        end
    end
    assign code_a      = a_reg;
    assign code_b      = b_reg;
    assign millivolt_a = mv_a_reg;
    assign millivolt_b = mv_b_reg;
endmodule : dac_serial_device

//--- verilog/dac_serial_host.sv
// host end: sends one 14-bit word, then pulses the load strobe
// assumes the converter samples serial clock on the same system clock
`include "serial_dac_map.svh"
module dac_serial_host
    import serial_dac_pkg::*;
(
    input  wire logic  clock,
    input  wire logic  rst_b,
    input  wire logic  clk_en,
    input  wire logic  req,
    input  wire logic  [1:0] addr,
    input  code_t      code,
    output logic       busy,
    serial_dac_if.host link
);
    typedef enum logic [2:0] {idle_s, low_s, high_s, desel_s, load_s, done_s} state_t;
    state_t      st_reg;
    word_t       word_reg;
    logic [3:0]  cnt_reg;
    logic        sdi_reg;
    logic        sclk_reg;
    logic        cs_n_reg;
    logic        ld_n_reg;
    logic        busy_reg;
    logic        last_w;
    assign last_w = (cnt_reg == 4'(`WORD_BITS - 1));

    // ****************************************
    // sequencer
    // ****************************************
    // one bit per two clocks: data set on low phase, clock rises on high phase
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg   <= idle_s;
            word_reg <= `WORD_RESET;
            cnt_reg  <= 4'h0;
            sdi_reg  <= 1'b0;
            sclk_reg <= 1'b0;
            cs_n_reg <= 1'b1;
            ld_n_reg <= 1'b1;
            busy_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            unique case (st_reg)
                idle_s:
                    if (req)
                    begin
                        word_reg <= {addr, code};
                        cnt_reg  <= 4'h0;
                        cs_n_reg <= 1'b0;
                        busy_reg <= 1'b1;
                        st_reg   <= low_s;
                    end
                low_s:
                begin
                    sclk_reg <= 1'b0;
                    sdi_reg  <= word_reg[`WORD_BITS-1];
                    word_reg <= {word_reg[`WORD_BITS-2:0], 1'b0};
                    st_reg   <= high_s;
                end
                high_s:
                begin
                    sclk_reg <= 1'b1;
                    cnt_reg  <= cnt_reg + 4'h1;
                    st_reg   <= last_w ? desel_s : low_s;
                end
                desel_s:
                begin
                    sclk_reg <= 1'b0;
                    cs_n_reg <= 1'b1;
                    st_reg   <= load_s;
                end
                load_s:
                begin
                    ld_n_reg <= 1'b0;
                    st_reg   <= done_s;
                end
                done_s:
                begin
                    ld_n_reg <= 1'b1;
                    busy_reg <= 1'b0;
                    st_reg   <= idle_s;
                end
            endcase
        end
    end
    // busy kept as a flop so the output carries no decode glitches
    assign busy                    = busy_reg;
    assign link.serial_in_line     = sdi_reg;
    assign link.serial_clk         = sclk_reg;
    assign link.chip_sel_n         = cs_n_reg;
    assign link.dac_latch_strobe_n = ld_n_reg;
endmodule : dac_serial_host

//--- sim/dac_link_sva.sv
// checker for the wires between host end and converter end
// assumes one clock and the link interface signals as inputs
module dac_link_sva
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic serial_in_line,
    input wire logic serial_clk,
    input wire logic chip_sel_n,
    input wire logic dac_latch_strobe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // link properties
    // ****************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    a_strobe_one_cycle: assert property ($fell(dac_latch_strobe_n) |=> dac_latch_strobe_n)
        else $error("load strobe low for more than one clock");
    a_load_deselected: assert property (!dac_latch_strobe_n |-> chip_sel_n)
        else $error("load strobe low while selected");
    a_clock_idle_desel: assert property (chip_sel_n |-> !serial_clk)
        else $error("serial clock high while deselected");
    a_strobe_after_word: assert property ($rose(chip_sel_n) |=> !dac_latch_strobe_n)
        else $error("no load right after the word");
    a_word_length: assert property ($fell(chip_sel_n) |-> ##29 $rose(chip_sel_n))
        else $error("word frame of wrong length");
    a_clock_single: assert property ($rose(serial_clk) |=> !serial_clk)
        else $error("serial clock high too long");
    a_data_held: assert property (serial_clk |-> $stable(serial_in_line))
        else $error("data moved while serial clock high");
    a_strobe_high_shift: assert property (!chip_sel_n |-> dac_latch_strobe_n)
        else $error("strobe low during shifting");
    c_load: cover property ($fell(dac_latch_strobe_n));
    c_frame: cover property ($fell(chip_sel_n));
    c_one_bit: cover property ($rose(serial_clk) && serial_in_line);
endmodule : dac_link_sva

//--- sim/tb_dual_dac_serial_load.sv
// testbench joining host end and converter end over the link
// assumes clk_en is low only during the idle freeze, so wire timing matches the fixed walk
module tb_dual_dac_serial_load;
    import serial_dac_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [1:0] ad; code_t cd; code_t ea; code_t eb;} row_t;
    logic        clock, rst_b, req, busy;
    logic        clk_en;
    logic [1:0]  addr;
    code_t       code, code_a, code_b;
    logic [15:0] mv_a, mv_b;
    int          miscompares, cmp_count, cycles;
    row_t        rows[5] = '{'{2'h0, 12'h800, 12'h800, 12'h800}, '{2'h3, 12'h801, 12'h800, 12'h801},
                             '{2'h2, 12'h7ff, 12'h7ff, 12'h801}, '{2'h1, 12'hfff, 12'hfff, 12'hfff},
                             '{2'h2, 12'h000, 12'h000, 12'hfff}};
    serial_dac_if link();
    dac_serial_host dac_serial_host_i(.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .req(req), .addr(addr),
        .code(code), .busy(busy), .link(link));
    dac_serial_device dac_serial_device_i(.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .link(link),
        .code_a(code_a), .code_b(code_b), .millivolt_a(mv_a), .millivolt_b(mv_b));
    dac_link_sva dac_link_sva_i(.clock(clock), .rst_b(rst_b), .serial_in_line(link.serial_in_line),
        .serial_clk(link.serial_clk), .chip_sel_n(link.chip_sel_n), .dac_latch_strobe_n(link.dac_latch_strobe_n));
    // ****************
    // clock and tasks
    // ****************
    always #50 clock = ~clock;
    // a run needs about 300 clocks, so 2000 means a hang
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            miscompares++;
            stop_test();
        end
    end
    task check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task send(input logic [1:0] a, input code_t c);
        @(negedge clock);
        req = 1'b1;
        addr = a;
        code = c;
        @(negedge clock);
        req = 1'b0;
    endtask : send
    // codes land one clock after the strobe, millivolts one more
    task wait_done;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 60)
        begin
            @(negedge clock);
            n++;
        end
        repeat (3) @(negedge clock);
    endtask : wait_done
    task stop_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    initial
    begin
        {clock, rst_b, req, addr, code} = '0;
        clk_en = 1'b1;
        repeat (2) @(negedge clock);
        check({13'h0, busy, link.chip_sel_n, link.dac_latch_strobe_n}, 16'h0003);
        check({4'h0, code_a ^ code_b}, 16'h0000);
        rst_b = 1'b1;
        foreach (rows[i])
        begin
            send(rows[i].ad, rows[i].cd);
            wait_done();
            check({4'h0, code_a}, {4'h0, rows[i].ea});
            check({4'h0, code_b}, {4'h0, rows[i].eb});
            check(mv_a, {4'h0, rows[i].ea});
            check(mv_b, {4'h0, rows[i].eb});
        end
        send(2'h2, 12'ha5a);
        repeat (12) @(negedge clock);
        check({4'h0, code_a}, 16'h0000);
        check({15'h0, busy}, 16'h0001);
        send(2'h3, 12'h123);
        wait_done();
        check({4'h0, code_a}, 16'h0a5a);
        check({4'h0, code_b}, 16'h0fff);
        // freeze while idle: a request held across the freeze must not start a word until clk_en returns
        clk_en = 1'b0;
        req = 1'b1;
        addr = 2'h3;
        code = 12'h5a5;
        repeat (4) @(negedge clock);
        check({15'h0, busy}, 16'h0000);
        check({15'h0, link.chip_sel_n}, 16'h0001);
        clk_en = 1'b1;
        @(negedge clock);
        req = 1'b0;
        wait_done();
        check({4'h0, code_b}, 16'h05a5);
        check({4'h0, code_a}, 16'h0a5a);
        stop_test();
    end
endmodule : tb_dual_dac_serial_load
